// >>> verilog/ppm_port_mux.sv
// ppm_port_mux: pin multiplexing and general-purpose port logic for ports 0 to 6.
// assumes pins are asynchronous and synchronised here; peripheral signals share sys_clk.
// Contract
// - port 0 is four bidirectional general-purpose pins
// - each port 0 pin has its own direction bit
// - port 0 pull-up only on an input pin whose pull-up bit is set
// - interrupt inputs detect rising, falling or both edges as software selects
// - one port 0 pin feeds the CAN controller external clock
// - port 1 is five input-only pins, port or analog per pin
// - port 1 control mode pins become the five analog input channels
// - port 2 is eight output-only pins, optionally meter PWM
// - port 2 control mode carries meter 1 and meter 2 PWM phases
// - each port 3 pin selects port or control mode and its function
// - port 3 control mode routes serial, 8-bit timer and four LCD segments
// - port 4 is eight bidirectional pins with per-bit direction
// - port 4 control mode drives LCD segments 0 to 7, whole byte
// - port 5 in port mode is eight output-only pins
// - port 5 control mode carries meter 3 and meter 4 PWM phases
// - port 6 is six bidirectional pins, mode chosen per pin
// - port 6 control mode routes timer, clock out, async serial, sound outputs
// - two port 6 pins trigger the 16-bit timer captures
// - sound amplitude shares a pin with clock out; input after reset
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module ppm_port_mux (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] port_zero_pins_in,
	output logic [3:0] port_zero_pins_out,
	output logic [3:0] port_zero_pins_oe_n,
	output logic [3:0] port_zero_pullup,
	input wire logic [4:0] port_one_pins_in,
	output logic [7:0] port_two_pins_out,
	output logic [7:0] port_two_pins_oe_n,
	input wire logic [3:0] port_three_pins_in,
	output logic [3:0] port_three_pins_out,
	output logic [3:0] port_three_pins_oe_n,
	input wire logic [7:0] port_four_pins_in,
	output logic [7:0] port_four_pins_out,
	output logic [7:0] port_four_pins_oe_n,
	output logic [7:0] port_five_pins_out,
	output logic [7:0] port_five_pins_oe_n,
	input wire logic [5:0] port_six_pins_in,
	output logic [5:0] port_six_pins_out,
	output logic [5:0] port_six_pins_oe_n,
	output logic [2:0] ext_irq_event,
	output logic can_ext_clock_in,
	output logic [4:0] analog_in_channels_en,
	input wire logic [3:0] meter1_pwm_phases,
	input wire logic [3:0] meter2_pwm_phases,
	input wire logic [3:0] meter3_pwm_phases,
	input wire logic [3:0] meter4_pwm_phases,
	output logic serial_a_data_in,
	input wire logic serial_a_data_out,
	output logic serial_a_clock_in,
	input wire logic serial_a_clock_out,
	output logic timer8_a_count_in,
	input wire logic timer8_a_out,
	input wire logic [3:0] lcd_segments_high_group,
	input wire logic [7:0] lcd_segments_low_group,
	output logic capture_trigger_a,
	output logic capture_trigger_b,
	output logic async_rx_in,
	input wire logic async_tx_out,
	input wire logic sound_combined_out,
	input wire logic sound_frequency_out,
	input wire logic sound_amplitude_out,
	input wire logic trim_clock_out
);
	typedef struct packed {
		logic [3:0] p0Latch;
		logic [3:0] p0Dir;
		logic [3:0] p0Pull;
		logic [3:0] p0Ctrl;
		logic [6:0] irqEdge;
		logic [4:0] p1Ctrl;
		logic [7:0] p2Latch;
		logic [7:0] p2Ctrl;
		logic [3:0] p3Latch;
		logic [3:0] p3Dir;
		logic [3:0] p3Ctrl;
		logic [3:0] p3Func;
		logic [7:0] p4Latch;
		logic [7:0] p4Dir;
		logic p4Ctrl;
		logic [7:0] p5Latch;
		logic [7:0] p5Ctrl;
		logic [5:0] p6Latch;
		logic [5:0] p6Dir;
		logic [5:0] p6Ctrl;
		logic [1:0] p6Func;
		logic [26:0] sync1;
		logic [26:0] sync2;
		logic [2:0] irqPrev;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic [3:0] p0Out;
		logic [3:0] p0OeN;
		logic [3:0] p0PullUp;
		logic [7:0] p2Out;
		logic [7:0] p2OeN;
		logic [3:0] p3Out;
		logic [3:0] p3OeN;
		logic [7:0] p4Out;
		logic [7:0] p4OeN;
		logic [7:0] p5Out;
		logic [7:0] p5OeN;
		logic [5:0] p6Out;
		logic [5:0] p6OeN;
		logic [2:0] irqEvt;
		logic canClk;
		logic [4:0] anaEn;
		logic serDin;
		logic serClkIn;
		logic tmrCountIn;
		logic capA;
		logic capB;
		logic rxIn;
	} ppm_state_t;

	ppm_state_t state_r;
	ppm_state_t state_nxt;

	// per-bit mux: control mode takes the peripheral value and drive, port mode the latch and dir
	function automatic logic [15:0] pinMux(input logic [7:0] ctrl, input logic [7:0] perVal,
			input logic [7:0] perDrive, input logic [7:0] latch, input logic [7:0] dir);
		logic [7:0] val;
		logic [7:0] oeN;
		val = (ctrl & perVal) | (~ctrl & latch);
		oeN = ~((ctrl & perDrive) | (~ctrl & dir));
		pinMux = {oeN, val};
	endfunction

	// synchronised pin views: [3:0] port 0, [8:4] port 1, [12:9] port 3, [20:13] port 4, [26:21] port 6
	logic [3:0] p0Pin;
	logic [4:0] p1Pin;
	logic [3:0] p3Pin;
	logic [7:0] p4Pin;
	logic [5:0] p6Pin;
	assign p0Pin = state_r.sync2[3:0];
	assign p1Pin = state_r.sync2[8:4];
	assign p3Pin = state_r.sync2[12:9];
	assign p4Pin = state_r.sync2[20:13];
	assign p6Pin = state_r.sync2[26:21];

	always_comb begin
		logic [15:0] mx;
		logic [7:0] p3Per;
		logic [7:0] p3Drv;
		logic [7:0] p6Per;
		logic [7:0] p6Drv;
		logic [2:0] rise;
		logic [2:0] fall;
		logic setup;
		logic wr;
		mx = 16'h0000;
		p3Per = 8'h00;
		p3Drv = 8'h00;
		p6Per = 8'h00;
		p6Drv = 8'h00;
		rise = 3'h0;
		fall = 3'h0;
		state_nxt = state_r;
		setup = psel && !penable;
		wr = psel && penable && state_r.ready && pwrite;
		state_nxt.ready = setup;
		state_nxt.slverr = 1'b0;
		state_nxt.rdata = ppm_pkg::DATA_ZERO;
		if (setup) begin
			case (paddr)
				ppm_pkg::P0_LATCH_OFS: state_nxt.rdata = {28'h0000000, state_r.p0Latch};
				ppm_pkg::P0_DIR_OFS: state_nxt.rdata = {28'h0000000, state_r.p0Dir};
				ppm_pkg::P0_PULLUP_OFS: state_nxt.rdata = {28'h0000000, state_r.p0Pull};
				ppm_pkg::P0_CTRL_OFS: state_nxt.rdata = {28'h0000000, state_r.p0Ctrl};
				ppm_pkg::IRQ_EDGE_OFS: state_nxt.rdata = {25'h0000000, state_r.irqEdge};
				ppm_pkg::P0_PIN_OFS: state_nxt.rdata = {28'h0000000, p0Pin};
				ppm_pkg::P1_CTRL_OFS: state_nxt.rdata = {27'h0000000, state_r.p1Ctrl};
				ppm_pkg::P1_PIN_OFS: state_nxt.rdata = {27'h0000000, p1Pin & ~state_r.p1Ctrl};
				ppm_pkg::P2_LATCH_OFS: state_nxt.rdata = {24'h000000, state_r.p2Latch};
				ppm_pkg::P2_CTRL_OFS: state_nxt.rdata = {24'h000000, state_r.p2Ctrl};
				ppm_pkg::P3_LATCH_OFS: state_nxt.rdata = {28'h0000000, state_r.p3Latch};
				ppm_pkg::P3_DIR_OFS: state_nxt.rdata = {28'h0000000, state_r.p3Dir};
				ppm_pkg::P3_CTRL_OFS: state_nxt.rdata = {28'h0000000, state_r.p3Ctrl};
				ppm_pkg::P3_FUNC_OFS: state_nxt.rdata = {28'h0000000, state_r.p3Func};
				ppm_pkg::P3_PIN_OFS: state_nxt.rdata = {28'h0000000, p3Pin};
				ppm_pkg::P4_LATCH_OFS: state_nxt.rdata = {24'h000000, state_r.p4Latch};
				ppm_pkg::P4_DIR_OFS: state_nxt.rdata = {24'h000000, state_r.p4Dir};
				ppm_pkg::P4_CTRL_OFS: state_nxt.rdata = {31'h00000000, state_r.p4Ctrl};
				ppm_pkg::P4_PIN_OFS: state_nxt.rdata = {24'h000000, p4Pin};
				ppm_pkg::P5_LATCH_OFS: state_nxt.rdata = {24'h000000, state_r.p5Latch};
				ppm_pkg::P5_CTRL_OFS: state_nxt.rdata = {24'h000000, state_r.p5Ctrl};
				ppm_pkg::P6_LATCH_OFS: state_nxt.rdata = {26'h0000000, state_r.p6Latch};
				ppm_pkg::P6_DIR_OFS: state_nxt.rdata = {26'h0000000, state_r.p6Dir};
				ppm_pkg::P6_CTRL_OFS: state_nxt.rdata = {26'h0000000, state_r.p6Ctrl};
				ppm_pkg::P6_FUNC_OFS: state_nxt.rdata = {30'h00000000, state_r.p6Func};
				ppm_pkg::P6_PIN_OFS: state_nxt.rdata = {26'h0000000, p6Pin};
				default: state_nxt.slverr = 1'b1;
			endcase
		end
		if (wr) begin
			case (paddr)
				ppm_pkg::P0_LATCH_OFS: state_nxt.p0Latch = pwdata[3:0];
				ppm_pkg::P0_DIR_OFS: state_nxt.p0Dir = pwdata[3:0];
				ppm_pkg::P0_PULLUP_OFS: state_nxt.p0Pull = pwdata[3:0];
				ppm_pkg::P0_CTRL_OFS: state_nxt.p0Ctrl = pwdata[3:0];
				ppm_pkg::IRQ_EDGE_OFS: state_nxt.irqEdge = pwdata[6:0];
				ppm_pkg::P1_CTRL_OFS: state_nxt.p1Ctrl = pwdata[4:0];
				ppm_pkg::P2_LATCH_OFS: state_nxt.p2Latch = pwdata[7:0];
				ppm_pkg::P2_CTRL_OFS: state_nxt.p2Ctrl = pwdata[7:0];
				ppm_pkg::P3_LATCH_OFS: state_nxt.p3Latch = pwdata[3:0];
				ppm_pkg::P3_DIR_OFS: state_nxt.p3Dir = pwdata[3:0];
				ppm_pkg::P3_CTRL_OFS: state_nxt.p3Ctrl = pwdata[3:0];
				ppm_pkg::P3_FUNC_OFS: state_nxt.p3Func = pwdata[3:0];
				ppm_pkg::P4_LATCH_OFS: state_nxt.p4Latch = pwdata[7:0];
				ppm_pkg::P4_DIR_OFS: state_nxt.p4Dir = pwdata[7:0];
				ppm_pkg::P4_CTRL_OFS: state_nxt.p4Ctrl = pwdata[0];
				ppm_pkg::P5_LATCH_OFS: state_nxt.p5Latch = pwdata[7:0];
				ppm_pkg::P5_CTRL_OFS: state_nxt.p5Ctrl = pwdata[7:0];
				ppm_pkg::P6_LATCH_OFS: state_nxt.p6Latch = pwdata[5:0];
				ppm_pkg::P6_DIR_OFS: state_nxt.p6Dir = pwdata[5:0];
				ppm_pkg::P6_CTRL_OFS: state_nxt.p6Ctrl = pwdata[5:0];
				ppm_pkg::P6_FUNC_OFS: state_nxt.p6Func = pwdata[1:0];
				default: state_nxt.p0Latch = state_r.p0Latch;
			endcase
		end
		// pin synchronisers: second stage feeds all logic
		state_nxt.sync1 = {port_six_pins_in, port_four_pins_in, port_three_pins_in,
			port_one_pins_in, port_zero_pins_in};
		state_nxt.sync2 = state_r.sync1;
		// port 0: interrupt pins and CAN clock are inputs in control mode
		mx = pinMux({4'h0, state_r.p0Ctrl}, 8'h00, 8'h00, {4'h0, state_r.p0Latch},
			{4'h0, state_r.p0Dir});
		state_nxt.p0Out = mx[3:0];
		state_nxt.p0OeN = mx[11:8];
		state_nxt.p0PullUp = state_r.p0Pull & ~state_r.p0Dir & ~state_r.p0Ctrl;
		state_nxt.irqPrev = p0Pin[2:0];
		rise = p0Pin[2:0] & ~state_r.irqPrev & state_r.irqEdge[ppm_pkg::IRQ_RISE_LSB +: 3];
		fall = ~p0Pin[2:0] & state_r.irqPrev & state_r.irqEdge[ppm_pkg::IRQ_FALL_LSB +: 3];
		state_nxt.irqEvt = (rise | fall) & state_r.p0Ctrl[2:0];
		state_nxt.canClk = p0Pin[ppm_pkg::P0_CAN_BIT] & state_r.p0Ctrl[ppm_pkg::P0_CAN_BIT];
		// port 1: control mode hands the pin to the converter
		state_nxt.anaEn = state_r.p1Ctrl;
		// port 2 and port 5: output only, tri-stated only in reset
		mx = pinMux(state_r.p2Ctrl, {meter2_pwm_phases, meter1_pwm_phases}, 8'hff,
			state_r.p2Latch, 8'hff);
		state_nxt.p2Out = mx[7:0];
		state_nxt.p2OeN = mx[15:8];
		mx = pinMux(state_r.p5Ctrl, {meter4_pwm_phases, meter3_pwm_phases}, 8'hff,
			state_r.p5Latch, 8'hff);
		state_nxt.p5Out = mx[7:0];
		state_nxt.p5OeN = mx[15:8];
		// port 3: func bit set picks LCD segment; clear picks serial or timer role
		for (int i = 0; i < 4; i++) begin
			if (state_r.p3Func[i]) begin
				p3Per[i] = lcd_segments_high_group[3 - i];
				p3Drv[i] = 1'b1;
			end else begin
				p3Drv[i] = state_r.p3Dir[i];
			end
		end
		if (!state_r.p3Func[0])
			p3Per[0] = timer8_a_out & state_r.p3Latch[0];
		if (!state_r.p3Func[1])
			p3Per[1] = serial_a_clock_out & state_r.p3Latch[1];
		if (!state_r.p3Func[2])
			p3Per[2] = serial_a_data_out & state_r.p3Latch[2];
		mx = pinMux({4'h0, state_r.p3Ctrl}, p3Per, p3Drv, {4'h0, state_r.p3Latch},
			{4'h0, state_r.p3Dir});
		state_nxt.p3Out = mx[3:0];
		state_nxt.p3OeN = mx[11:8];
		state_nxt.tmrCountIn = p3Pin[0] & state_r.p3Ctrl[0] & ~state_r.p3Func[0];
		state_nxt.serClkIn = p3Pin[1] & state_r.p3Ctrl[1] & ~state_r.p3Func[1];
		state_nxt.serDin = p3Pin[3] & state_r.p3Ctrl[3] & ~state_r.p3Func[3];
		// port 4: whole byte goes to the LCD segment group at once
		mx = pinMux({8{state_r.p4Ctrl}}, lcd_segments_low_group, 8'hff, state_r.p4Latch,
			state_r.p4Dir);
		state_nxt.p4Out = mx[7:0];
		state_nxt.p4OeN = mx[15:8];
		// port 6: 0 sound, 1 amplitude or trim clock, 2 rx, 3 tx, 4/5 captures
		p6Per[0] = state_r.p6Func[ppm_pkg::P6_FUNC_FREQ_BIT] ? sound_frequency_out
			: sound_combined_out;
		p6Per[1] = state_r.p6Func[ppm_pkg::P6_FUNC_TRIM_BIT] ? trim_clock_out
			: sound_amplitude_out;
		p6Per[3] = async_tx_out;
		p6Drv = 8'h0b;
		mx = pinMux({2'h0, state_r.p6Ctrl}, p6Per, p6Drv, {2'h0, state_r.p6Latch},
			{2'h0, state_r.p6Dir});
		state_nxt.p6Out = mx[5:0];
		state_nxt.p6OeN = mx[13:8];
		state_nxt.rxIn = p6Pin[2] & state_r.p6Ctrl[2];
		state_nxt.capA = p6Pin[4] & state_r.p6Ctrl[4];
		state_nxt.capB = p6Pin[5] & state_r.p6Ctrl[5];
		if (!reset_n) begin
			state_nxt = '0;
			state_nxt.p0OeN = 4'hf;
			state_nxt.p2OeN = 8'hff;
			state_nxt.p3OeN = 4'hf;
			state_nxt.p4OeN = 8'hff;
			state_nxt.p5OeN = 8'hff;
			state_nxt.p6OeN = 6'h3f;
		end
	end

	always_ff @(posedge sys_clk) begin
		state_r <= state_nxt;
	end

	assign prdata = state_r.rdata;
	assign pready = state_r.ready;
	assign pslverr = state_r.slverr;
	assign port_zero_pins_out = state_r.p0Out;
	assign port_zero_pins_oe_n = state_r.p0OeN;
	assign port_zero_pullup = state_r.p0PullUp;
	assign port_two_pins_out = state_r.p2Out;
	assign port_two_pins_oe_n = state_r.p2OeN;
	assign port_three_pins_out = state_r.p3Out;
	assign port_three_pins_oe_n = state_r.p3OeN;
	assign port_four_pins_out = state_r.p4Out;
	assign port_four_pins_oe_n = state_r.p4OeN;
	assign port_five_pins_out = state_r.p5Out;
	assign port_five_pins_oe_n = state_r.p5OeN;
	assign port_six_pins_out = state_r.p6Out;
	assign port_six_pins_oe_n = state_r.p6OeN;
	assign ext_irq_event = state_r.irqEvt;
	assign can_ext_clock_in = state_r.canClk;
	assign analog_in_channels_en = state_r.anaEn;
	assign serial_a_data_in = state_r.serDin;
	assign serial_a_clock_in = state_r.serClkIn;
	assign timer8_a_count_in = state_r.tmrCountIn;
	assign capture_trigger_a = state_r.capA;
	assign capture_trigger_b = state_r.capB;
	assign async_rx_in = state_r.rxIn;
endmodule

// >>> include/ppm_pkg.sv
// ppm_pkg: register map, reset values and field positions of the port pin mux.
// assumes a 32-bit APB slave with one register per aligned word.
package ppm_pkg;
	localparam int ADDR_W = 8;
	// per-port output latch, direction (1 = output), control mode, pull-up, function
	localparam logic [7:0] P0_LATCH_OFS = 8'h00;
	localparam logic [7:0] P0_DIR_OFS = 8'h04;
	localparam logic [7:0] P0_PULLUP_OFS = 8'h08;
	localparam logic [7:0] P0_CTRL_OFS = 8'h0c;
	localparam logic [7:0] IRQ_EDGE_OFS = 8'h10;
	localparam logic [7:0] P0_PIN_OFS = 8'h14;
	localparam logic [7:0] P1_CTRL_OFS = 8'h18;
	localparam logic [7:0] P1_PIN_OFS = 8'h1c;
	localparam logic [7:0] P2_LATCH_OFS = 8'h20;
	localparam logic [7:0] P2_CTRL_OFS = 8'h24;
	localparam logic [7:0] P3_LATCH_OFS = 8'h28;
	localparam logic [7:0] P3_DIR_OFS = 8'h2c;
	localparam logic [7:0] P3_CTRL_OFS = 8'h30;
	localparam logic [7:0] P3_FUNC_OFS = 8'h34;
	localparam logic [7:0] P3_PIN_OFS = 8'h38;
	localparam logic [7:0] P4_LATCH_OFS = 8'h3c;
	localparam logic [7:0] P4_DIR_OFS = 8'h40;
	localparam logic [7:0] P4_CTRL_OFS = 8'h44;
	localparam logic [7:0] P4_PIN_OFS = 8'h48;
	localparam logic [7:0] P5_LATCH_OFS = 8'h4c;
	localparam logic [7:0] P5_CTRL_OFS = 8'h50;
	localparam logic [7:0] P6_LATCH_OFS = 8'h54;
	localparam logic [7:0] P6_DIR_OFS = 8'h58;
	localparam logic [7:0] P6_CTRL_OFS = 8'h5c;
	localparam logic [7:0] P6_FUNC_OFS = 8'h60;
	localparam logic [7:0] P6_PIN_OFS = 8'h64;
	// irq edge register: rise enables in [2:0], fall enables in [6:4]
	localparam int IRQ_RISE_LSB = 0;
	localparam int IRQ_FALL_LSB = 4;
	// port 6 function bits: pin 0 frequency vs combined sound, pin 1 trim clock vs amplitude
	localparam int P6_FUNC_FREQ_BIT = 0;
	localparam int P6_FUNC_TRIM_BIT = 1;
	// port 0 pin carrying the CAN clock input
	localparam int P0_CAN_BIT = 3;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage

// >>> testbench/ppm_port_mux_sva.sv
// ppm_port_mux_sva: concurrent checks on the port pin mux top-level ports.
// assumes one sys_clk domain, synchronous active-low reset, bound to ppm_port_mux.
`timescale 1ns/1ps
module ppm_port_mux_sva (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] port_zero_pins_in,
	input wire logic [3:0] port_zero_pins_oe_n,
	input wire logic [3:0] port_zero_pullup,
	input wire logic [7:0] port_two_pins_oe_n,
	input wire logic [7:0] port_five_pins_oe_n,
	input wire logic [5:0] port_six_pins_in,
	input wire logic [5:0] port_six_pins_oe_n,
	input wire logic [2:0] ext_irq_event,
	input wire logic can_ext_clock_in,
	input wire logic [4:0] analog_in_channels_en,
	input wire logic capture_trigger_a
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	zero_wait_a: assert property (psel && !penable |=> pready)
		else $error("pready missing in access cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	meter_drive_a: assert property ($past(reset_n) |->
		port_two_pins_oe_n == 8'h00 && port_five_pins_oe_n == 8'h00)
		else $error("output-only port not driven");
	pull_input_a: assert property ((port_zero_pullup & ~port_zero_pins_oe_n) == 4'h0)
		else $error("pull-up on driven pin");
	irq_pulse_a: assert property (ext_irq_event[0] |=> !ext_irq_event[0])
		else $error("irq event wider than one cycle");
	can_clock_a: assert property (can_ext_clock_in |-> $past(port_zero_pins_in[3], 3))
		else $error("can clock high without pin high");
	capture_in_a: assert property (capture_trigger_a |-> $past(port_six_pins_in[4], 3))
		else $error("capture trigger without pin high");
	analog_sel_a: assert property (!$stable(analog_in_channels_en) |->
		$past(psel && penable && pwrite && paddr == ppm_pkg::P1_CTRL_OFS, 2))
		else $error("analog select changed without write");
	amp_input_a: assert property ($rose(reset_n) |-> port_six_pins_oe_n == 6'h3f)
		else $error("port 6 driven at reset release");
endmodule
bind ppm_port_mux ppm_port_mux_sva ppm_port_mux_sva_i (.*);

// >>> testbench/ppm_board_model.sv
// ppm_board_model: board pins of port 0 and the peripheral blocks around the mux.
// assumes the bench sets pv for peripheral outputs and board0/boardEn0 for port 0.
`timescale 1ns/1ps
module ppm_board_model (
	input wire logic sys_clk,
	input wire logic [7:0] pv,
	input wire logic [3:0] board0,
	input wire logic [3:0] boardEn0,
	input wire logic [3:0] port_zero_pins_out,
	input wire logic [3:0] port_zero_pins_oe_n,
	input wire logic [3:0] port_zero_pullup,
	output logic [3:0] port_zero_pins_in,
	output logic [3:0] meter1_pwm_phases,
	output logic [3:0] meter2_pwm_phases,
	output logic [3:0] meter3_pwm_phases,
	output logic [3:0] meter4_pwm_phases,
	output logic [3:0] lcd_segments_high_group,
	output logic [7:0] lcd_segments_low_group,
	output logic serial_a_data_out,
	output logic serial_a_clock_out,
	output logic timer8_a_out,
	output logic async_tx_out,
	output logic sound_combined_out,
	output logic sound_frequency_out,
	output logic sound_amplitude_out,
	output logic trim_clock_out
);
	logic tog = 1'b0;
	// a floating pin without pull-up wanders rather than holding its last level
	always @(posedge sys_clk) tog <= ~tog;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			port_zero_pins_in[i] = !port_zero_pins_oe_n[i] ? port_zero_pins_out[i] :
				boardEn0[i] ? board0[i] : port_zero_pullup[i] ? 1'b1 : tog;
		end
	end
	assign meter1_pwm_phases = pv[3:0];
	assign meter2_pwm_phases = ~pv[3:0];
	assign meter3_pwm_phases = pv[7:4];
	assign meter4_pwm_phases = ~pv[7:4];
	assign lcd_segments_high_group = pv[3:0];
	assign lcd_segments_low_group = ~pv;
	assign sound_combined_out = pv[0];
	assign sound_frequency_out = pv[1];
	assign sound_amplitude_out = pv[2];
	assign trim_clock_out = pv[3];
	assign timer8_a_out = pv[4];
	assign async_tx_out = pv[5];
	assign serial_a_data_out = pv[6];
	assign serial_a_clock_out = pv[7];
endmodule

// >>> testbench/tb_port_pin_function_mux.sv
// tb_port_pin_function_mux: APB-driven tests of the port pin mux.
// assumes zero-wait APB slave and the board model for port 0 and peripherals.
`timescale 1ns/1ps
module tb_port_pin_function_mux;
	logic sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, pv = 8'h6a, port_four_pins_in = 8'ha0;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic pready, pslverr, rerr, can_ext_clock_in, serial_a_data_in, serial_a_clock_in;
	logic timer8_a_count_in, capture_trigger_a, capture_trigger_b, async_rx_in;
	logic serial_a_data_out, serial_a_clock_out, timer8_a_out, async_tx_out, trim_clock_out;
	logic sound_combined_out, sound_frequency_out, sound_amplitude_out;
	logic [3:0] board0 = 4'h0, boardEn0 = 4'h0, port_three_pins_in = 4'h8;
	logic [3:0] port_zero_pins_in, port_zero_pins_out, port_zero_pins_oe_n, port_zero_pullup;
	logic [3:0] port_three_pins_out, port_three_pins_oe_n, lcd_segments_high_group;
	logic [3:0] meter1_pwm_phases, meter2_pwm_phases, meter3_pwm_phases, meter4_pwm_phases;
	logic [4:0] port_one_pins_in = 5'h1f, analog_in_channels_en;
	logic [7:0] port_two_pins_out, port_two_pins_oe_n, port_four_pins_out, port_four_pins_oe_n;
	logic [7:0] port_five_pins_out, port_five_pins_oe_n, lcd_segments_low_group;
	logic [5:0] port_six_pins_in = 6'h34, port_six_pins_out, port_six_pins_oe_n;
	logic [2:0] ext_irq_event;
	logic [7:0] cfg [3] = '{8'h07, 8'h70, 8'h77};
	int er [3] = '{1, 0, 1};
	int ef [3] = '{0, 1, 1};
	int failures = 0, cmp_count = 0, n;
	ppm_port_mux ppm_port_mux_i (.*);
	ppm_board_model ppm_board_model_i (.*);
	always #4 sys_clk = ~sys_clk;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// only the watchdog ends a wait for pready
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
		apb(1'b0, a, 32'h0);
		chk($sformatf("read %h", a), rdata, exp);
		chk("pslverr", rerr, err);
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge sys_clk);
	endtask
	task automatic pulses(output int cnt);
		cnt = 0;
		repeat (10) begin
			@(posedge sys_clk);
			if (ext_irq_event === 3'h7) cnt++;
		end
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		#50us;
		failures++;
		tally_and_finish;
	end
	initial begin
		cyc(3);
		reset_n <= 1'b1;
		cyc(2);
		chk("p2 oe", port_two_pins_oe_n, 8'h00);
		chk("p5 oe", port_five_pins_oe_n, 8'h00);
		chk("p6 oe", port_six_pins_oe_n, 6'h3f);
		rd(ppm_pkg::P6_CTRL_OFS, 32'h0, 1'b0);
		rd(8'hfc, 32'h0, 1'b1);
		wr(ppm_pkg::P0_LATCH_OFS, 32'h5);
		wr(ppm_pkg::P0_DIR_OFS, 32'h3);
		wr(ppm_pkg::P0_PULLUP_OFS, 32'hf);
		cyc(5);
		chk("p0 out", port_zero_pins_out[1:0], 2'b01);
		chk("p0 oe", port_zero_pins_oe_n, 4'hc);
		chk("p0 pull", port_zero_pullup, 4'hc);
		rd(ppm_pkg::P0_PIN_OFS, 32'hd, 1'b0);
		wr(ppm_pkg::P0_DIR_OFS, 32'h0);
		wr(ppm_pkg::P0_PULLUP_OFS, 32'h0);
		boardEn0 <= 4'hf;
		wr(ppm_pkg::P0_CTRL_OFS, 32'hf);
		for (int m = 0; m < 3; m++) begin
			wr(ppm_pkg::IRQ_EDGE_OFS, {24'h0, cfg[m]});
			cyc(6);
			board0 <= 4'hf;
			pulses(n);
			chk("rise events", n, er[m]);
			board0 <= 4'h0;
			pulses(n);
			chk("fall events", n, ef[m]);
		end
		board0 <= 4'hf;
		cyc(5);
		chk("can clock", can_ext_clock_in, 1'b1);
		board0 <= 4'h0;
		cyc(5);
		chk("can clock", can_ext_clock_in, 1'b0);
		wr(ppm_pkg::P1_CTRL_OFS, 32'h15);
		cyc(3);
		chk("analog sel", analog_in_channels_en, 5'h15);
		rd(ppm_pkg::P1_PIN_OFS, 32'h0a, 1'b0);
		wr(ppm_pkg::P2_LATCH_OFS, 32'ha5);
		wr(ppm_pkg::P5_LATCH_OFS, 32'h5a);
		cyc(3);
		chk("p2 out", port_two_pins_out, 8'ha5);
		chk("p5 out", port_five_pins_out, 8'h5a);
		rd(ppm_pkg::P2_LATCH_OFS, 32'ha5, 1'b0);
		wr(ppm_pkg::P2_CTRL_OFS, 32'hff);
		wr(ppm_pkg::P5_CTRL_OFS, 32'hff);
		cyc(3);
		chk("p2 meter", port_two_pins_out, {meter2_pwm_phases, meter1_pwm_phases});
		chk("p5 meter", port_five_pins_out, {meter4_pwm_phases, meter3_pwm_phases});
		wr(ppm_pkg::P4_LATCH_OFS, 32'h3c);
		wr(ppm_pkg::P4_DIR_OFS, 32'h0f);
		cyc(3);
		chk("p4 oe", port_four_pins_oe_n, 8'hf0);
		chk("p4 out", port_four_pins_out[3:0], 4'hc);
		wr(ppm_pkg::P4_CTRL_OFS, 32'h1);
		cyc(3);
		chk("p4 lcd", port_four_pins_out, lcd_segments_low_group);
		chk("p4 lcd oe", port_four_pins_oe_n, 8'h00);
		wr(ppm_pkg::P3_FUNC_OFS, 32'hf);
		wr(ppm_pkg::P3_CTRL_OFS, 32'hf);
		cyc(3);
		chk("p3 lcd", port_three_pins_out, {lcd_segments_high_group[0], lcd_segments_high_group[1],
			lcd_segments_high_group[2], lcd_segments_high_group[3]});
		wr(ppm_pkg::P3_FUNC_OFS, 32'h0);
		wr(ppm_pkg::P3_LATCH_OFS, 32'h4);
		wr(ppm_pkg::P3_DIR_OFS, 32'h4);
		cyc(5);
		chk("p3 oe", port_three_pins_oe_n, 4'hb);
		chk("p3 sdo", port_three_pins_out[2], serial_a_data_out);
		chk("sdi", serial_a_data_in, 1'b1);
		chk("t8 in", timer8_a_count_in, 1'b0);
		chk("sck in", serial_a_clock_in, 1'b0);
		wr(ppm_pkg::P6_CTRL_OFS, 32'h3f);
		wr(ppm_pkg::P6_FUNC_OFS, 32'h3);
		cyc(5);
		chk("p6 oe", port_six_pins_oe_n, 6'h34);
		chk("p6 out", port_six_pins_out & 6'h0b, 6'h0b);
		chk("rx", async_rx_in, 1'b1);
		chk("capture", {capture_trigger_a, capture_trigger_b}, 2'b11);
		// combined and amplitude outputs high so the routing differs from the zero latch
		pv <= 8'h65;
		wr(ppm_pkg::P6_FUNC_OFS, 32'h0);
		cyc(3);
		chk("p6 sound", port_six_pins_out[1:0], 2'b11);
		tally_and_finish;
	end
endmodule
